// ---- logic/sadc_core.sv ----
// converter control: register slave, bit clock, sequencer and pin map
//
// Register access over APB was decided locally.
`timescale 1ns/100ps

module sadc_core (
    input wire logic pclk, // 250 MHz oscillator, also the bus clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [sadc_pkg::PADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic cmp_above, // comparator: held input >= trial level
    input wire logic rc_half_tick, // internal rc clock, half period pulse
    input wire logic sleep_mode, // device sleeping, oscillator stopped
    output logic [7:0] dac_trial, // trial level to the comparator dac
    output logic sample_hold, // high while the hold cap is isolated
    output logic [2:0] channel_select, // analog mux select
    output logic [4:0] analog_pins, // pins ch4..ch0 in analog mode
    output logic ext_reference, // channel3 pin used as reference
    output logic converter_power_on, // analog power enable
    output logic conversion_done_flag // sticky completion flag
);
    import sadc_pkg::*;

    // ========================================
    // state
    logic [1:0] cs_ff;
    logic [2:0] chan_ff;
    logic go_ff;
    logic pwr_ff;
    logic [2:0] pcfg_ff;
    logic done_ff;
    logic [7:0] result_ff;
    sadc_state_t state_ff;
    logic [4:0] half_cnt_ff;
    logic [4:0] div_cnt_ff;
    logic [7:0] trial_ff;
    logic hold_ff;
    logic [4:0] pins_ff;
    logic ref_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;

    logic bus_done;
    logic wr_ok;
    logic wr_ctrl0;
    logic wr_pcfg;
    logic wr_status;
    logic mapped;
    logic start_req;
    logic off_req;
    logic half_tick;
    logic conv_done_evt;
    logic [7:0] nxt_trial;
    logic [31:0] nxt_prdata;
    logic [5:0] nxt_pinmap;

    // ========================================
    // apb slave
    // one wait-free access: data and ready are registered in the setup cycle
    assign bus_done = psel & penable & pready_ff;
    assign wr_ok = bus_done & pwrite & pstrb[0] & ~pslverr_ff;
    assign wr_ctrl0 = wr_ok & (paddr == sadc_addr(IDX_CTRL0));
    assign wr_pcfg = wr_ok & (paddr == sadc_addr(IDX_PCFG));
    assign wr_status = wr_ok & (paddr == sadc_addr(IDX_STATUS));

    // address decode and read mux; unused bits read as zero
    always_comb begin
        mapped = 1'b1;
        nxt_prdata = 32'h0000_0000;
        case (paddr)
            sadc_addr(IDX_CTRL0): // bit 1 reads zero
                nxt_prdata[7:0] = {cs_ff, chan_ff, go_ff, 1'b0, pwr_ff};
            sadc_addr(IDX_PCFG):
                nxt_prdata[2:0] = pcfg_ff;
            sadc_addr(IDX_RESULT):
                nxt_prdata[7:0] = result_ff;
            sadc_addr(IDX_STATUS): begin
                nxt_prdata[DONE_BIT] = done_ff;
                nxt_prdata[BUSY_BIT] = state_ff == SADC_CONV;
            end
            default:
                mapped = 1'b0;
        endcase
    end

    // ready rises for the access phase only, then drops for the next setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else if (psel & ~penable) begin
            pready_ff <= 1'b1;
            pslverr_ff <= ~mapped;
            prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
        end else begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    // ========================================
    // control registers
    // go is refused unless the converter was already powered
    assign start_req = wr_ctrl0 & pwdata[GO_BIT] & pwdata[PWR_BIT] & pwr_ff
        & (state_ff == SADC_IDLE);
    assign off_req = wr_ctrl0 & ~pwdata[PWR_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_ff <= CS_RST;
            chan_ff <= CH_RST;
            pwr_ff <= 1'b0;
            pcfg_ff <= PCFG_RST;
        end else begin
            if (wr_ctrl0) begin
                cs_ff <= pwdata[CS_LO+1:CS_LO];
                chan_ff <= pwdata[CH_LO+2:CH_LO];
                pwr_ff <= pwdata[PWR_BIT];
            end
            if (wr_pcfg) begin
                pcfg_ff <= pwdata[2:0];
            end
        end
    end

    // go: set by an accepted start, cleared at completion or power off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go_ff <= 1'b0;
        end else if (off_req || conv_done_evt) begin
            go_ff <= 1'b0;
        end else if (start_req) begin
            go_ff <= 1'b1;
        end
    end

    // done flag: write one clears, a completion in the same cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_ff <= 1'b0;
        end else if (conv_done_evt) begin
            done_ff <= 1'b1;
        end else if (wr_status && pwdata[DONE_BIT]) begin
            done_ff <= 1'b0;
        end
    end

    // ========================================
    // bit clock: half-period pulses from the divider or the rc clock
    // the oscillator stops in sleep, so only the rc clock keeps going
    always_comb begin
        half_tick = 1'b0;
        if (state_ff == SADC_CONV) begin
            if (cs_ff == CS_RC) begin
                half_tick = rc_half_tick;
            end else if (!sleep_mode) begin
                half_tick = div_cnt_ff == sadc_half_len(cs_ff) - 5'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_ff <= 5'h00;
        end else if (state_ff != SADC_CONV || half_tick) begin
            div_cnt_ff <= 5'h00;
        end else if (!sleep_mode && cs_ff != CS_RC) begin
            div_cnt_ff <= div_cnt_ff + 5'h01;
        end
    end

    // ========================================
    // sequencer: decide one bit at each odd half tick, msb first
    always_comb begin
        nxt_trial = trial_ff;
        if (half_cnt_ff[0] && half_cnt_ff < 5'h10) begin
            nxt_trial[3'h7 - half_cnt_ff[3:1]] = cmp_above;
            if (half_cnt_ff[3:1] != 3'h7) begin
                nxt_trial[3'h6 - half_cnt_ff[3:1]] = 1'b1;
            end
        end
    end

    // nine and a half bit periods after start
    assign conv_done_evt = half_tick && half_cnt_ff == CONV_HALVES - 5'h01;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= SADC_IDLE;
            half_cnt_ff <= 5'h00;
            trial_ff <= 8'h00;
            hold_ff <= 1'b0;
        end else begin
            case (state_ff)
                SADC_IDLE: begin
                    if (start_req) begin
                        state_ff <= SADC_CONV;
                        half_cnt_ff <= 5'h00;
                        trial_ff <= 8'h80;
                        hold_ff <= 1'b1;
                    end
                end
                SADC_CONV: begin
                    if (off_req || conv_done_evt) begin
                        state_ff <= SADC_IDLE;
                        hold_ff <= 1'b0;
                    end else if (half_tick) begin
                        half_cnt_ff <= half_cnt_ff + 5'h01;
                        trial_ff <= nxt_trial;
                    end
                end
                default: begin
                    state_ff <= SADC_IDLE;
                end
            endcase
        end
    end

    // result has no reset so that a reset leaves it untouched
    always_ff @(posedge pclk) begin
        if (conv_done_evt && !off_req) begin
            result_ff <= nxt_trial;
        end
    end

    // ========================================
    // pin map
    always_comb begin
        case (pcfg_ff)
            3'h0, 3'h2: nxt_pinmap = 6'h1f;
            3'h1, 3'h3: nxt_pinmap = 6'h37;
            3'h4: nxt_pinmap = 6'h0b;
            3'h5: nxt_pinmap = 6'h23;
            default: nxt_pinmap = 6'h00;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_ff <= 5'h1f;
            ref_ff <= 1'b0;
        end else begin
            pins_ff <= nxt_pinmap[4:0];
            ref_ff <= nxt_pinmap[5];
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign dac_trial = trial_ff;
    assign sample_hold = hold_ff;
    assign channel_select = chan_ff;
    assign analog_pins = pins_ff;
    assign ext_reference = ref_ff;
    assign converter_power_on = pwr_ff;
    assign conversion_done_flag = done_ff;

    // ========================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [4:0] halves_seen_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halves_seen_ff <= 5'h00;
        end else if (start_req) begin
            halves_seen_ff <= 5'h00;
        end else if (half_tick) begin
            halves_seen_ff <= halves_seen_ff + 5'h01;
        end
    end

    sequence seq_finish;
        !go_ff && done_ff && state_ff == SADC_IDLE;
    endsequence

    done_clears_go_a: assert property (conv_done_evt && !off_req
        |=> seq_finish)
        else $error("completion did not clear go and set done");
    result_load_a: assert property (conv_done_evt && !off_req
        |=> result_ff == $past(nxt_trial))
        else $error("result not loaded at completion");
    conv_length_a: assert property (conv_done_evt
        |-> halves_seen_ff == 5'h12)
        else $error("conversion not nine and a half bit periods");
    off_ignores_go_a: assert property (!pwr_ff |=> !go_ff)
        else $error("go set while converter off");
    power_abort_a: assert property (off_req
        |=> !go_ff && state_ff == SADC_IDLE && !sample_hold)
        else $error("power off did not abort");
    msb_first_a: assert property (start_req
        |=> trial_ff == 8'h80 && sample_hold ##1 trial_ff[7])
        else $error("sequence did not start at msb");
    sleep_freeze_a: assert property (sleep_mode && cs_ff != CS_RC
        |-> !half_tick)
        else $error("bit clock ran in sleep without rc clock");
    div2_rate_a: assert property (half_tick && cs_ff == CS_DIV2
        && !sleep_mode |=> half_tick || state_ff == SADC_IDLE
        || sleep_mode || cs_ff != CS_DIV2)
        else $error("osc/2 bit clock rate wrong");
    all_digital_a: assert property (pcfg_ff[2:1] == 2'b11
        |=> analog_pins == 5'h00 && !ext_reference)
        else $error("pins not all digital");
    reserved_zero_a: assert property (psel && !penable && !pwrite
        && paddr == sadc_addr(IDX_PCFG) |=> prdata[31:3] == 29'h0)
        else $error("reserved bits read nonzero");
endmodule

// ---- pkg/sadc_pkg.sv ----
// constants, field layout and helper functions of the converter control block
package sadc_pkg;
    // ========================================
    // register map: printed indices, byte address is four times the index
    localparam int PADDR_W = 10;
    localparam logic [7:0] IDX_RESULT = 8'h1e;
    localparam logic [7:0] IDX_CTRL0 = 8'h1f;
    localparam logic [7:0] IDX_PCFG = 8'h9f;
    localparam logic [7:0] IDX_STATUS = 8'ha0;
    // ========================================
    // field positions
    localparam int CS_LO = 6;
    localparam int CH_LO = 3;
    localparam int GO_BIT = 2;
    localparam int PWR_BIT = 0;
    localparam int DONE_BIT = 0;
    localparam int BUSY_BIT = 1;
    // ========================================
    // reset values
    localparam logic [1:0] CS_RST = 2'h0;
    localparam logic [2:0] CH_RST = 3'h0;
    localparam logic [2:0] PCFG_RST = 3'h0;
    // ========================================
    // conversion clock select codes
    localparam logic [1:0] CS_DIV2 = 2'h0;
    localparam logic [1:0] CS_DIV8 = 2'h1;
    localparam logic [1:0] CS_DIV32 = 2'h2;
    localparam logic [1:0] CS_RC = 2'h3;
    // ========================================
    // timing: pclk cycles per half bit period, half periods per conversion
    localparam logic [4:0] HALF_DIV2 = 5'h01;
    localparam logic [4:0] HALF_DIV8 = 5'h04;
    localparam logic [4:0] HALF_DIV32 = 5'h10;
    localparam logic [4:0] CONV_HALVES = 5'h13;
    localparam int RESULT_W = 8;
    localparam int NUM_CH = 5;

    typedef enum logic {
        SADC_IDLE = 1'b0,
        SADC_CONV = 1'b1
    } sadc_state_t;

    // byte address of a register index
    function automatic logic [PADDR_W-1:0] sadc_addr(input logic [7:0] idx);
        return {idx, 2'b00};
    endfunction

    // pclk cycles per half bit period for a divided clock selection
    function automatic logic [4:0] sadc_half_len(input logic [1:0] cs);
        case (cs)
            CS_DIV2: return HALF_DIV2;
            CS_DIV8: return HALF_DIV8;
            default: return HALF_DIV32;
        endcase
    endfunction
endpackage

// ---- bench/tb_top.sv ----
// self-checking bench of the converter control block over apb
`timescale 1ns/100ps

module tb_top;
    import sadc_pkg::*;
    // ========================================
    // stimulus and observed signals
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [PADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic rc_half_tick = 1'h0;
    logic sleep_mode = 1'h0;
    logic rc_run = 1'h0;
    logic [1:0] rc_cnt = 2'h0;
    logic [7:0] vin = 8'h00; // level on a pin kept an input
    logic cmp_above;
    logic [31:0] prdata;
    logic pready, pslverr, sample_hold, ext_reference, pwr_on, done;
    logic [7:0] dac_trial;
    logic [2:0] channel_select;
    logic [4:0] analog_pins;
    logic [31:0] rd;
    logic err;
    logic [4:0] pins_exp [8] = '{5'h1f, 5'h17, 5'h1f, 5'h17,
                                 5'h0b, 5'h03, 5'h00, 5'h00};
    logic [7:0] ref_exp = 8'h2a;
    int fail_count = 0;
    int num_checks = 0;
    int n;

    // 4 ns clock
    always #2 pclk = ~pclk;

    // ideal comparator: held input against the trial level
    assign cmp_above = (vin >= dac_trial);

    // rc clock model, one half tick every third pclk, so it has no
    // fixed phase to the divided clocks
    always @(posedge pclk) begin
        rc_cnt <= (rc_cnt == 2'h2) ? 2'h0 : rc_cnt + 2'h1;
        rc_half_tick <= rc_run && (rc_cnt == 2'h2);
    end

    sadc_core sadc_core_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_above(cmp_above), .rc_half_tick(rc_half_tick),
        .sleep_mode(sleep_mode), .dac_trial(dac_trial),
        .sample_hold(sample_hold), .channel_select(channel_select),
        .analog_pins(analog_pins), .ext_reference(ext_reference),
        .converter_power_on(pwr_on), .conversion_done_flag(done)
    );

    // ========================================
    // report and compare tasks
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_cnt(input string what, input int lo, input int hi,
                           input int got);
        num_checks++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("mismatch %s expected %0d seen %0d", what, lo, got);
        end
    endtask

    // ========================================
    // apb transfer: request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'h1 && k < 16);
        if (k >= 16) begin
            fail_count++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // bounded wait for the done flag, n keeps counting cycles
    task automatic wait_done(input int lim);
        while (done !== 1'h1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
        if (n >= lim) begin
            fail_count++;
            summarize();
        end
    endtask

    // one full conversion; the time is 9.5 bit periods of 2, 8, 32 or, for the rc model, 6 pclk
    task automatic conv(input logic [1:0] cs, input logic [7:0] v);
        logic [31:0] c0;
        int t;
        c0 = {24'h0, cs, 3'h2, 3'h1};
        t = (cs == CS_DIV2) ? 19 : (cs == CS_DIV8) ? 76 : 304;
        if (cs == CS_RC) begin
            t = 57;
        end
        vin <= v;
        apb(1'h1, IDX_CTRL0, c0);
        repeat (8) @(posedge pclk); // acquisition and gap
        apb(1'h1, IDX_CTRL0, c0 | 32'h4);
        @(posedge pclk);
        chk("sample hold", 32'h1, {31'h0, sample_hold});
        chk("first trial", 32'h80, {24'h0, dac_trial});
        n = 1;
        wait_done(t + 40);
        if (cs != CS_RC) begin
            chk_cnt("conversion time", t, t + 2, n);
        end else begin
            // rc model ticks every third pclk, first tick phase is free
            chk_cnt("rc conversion time", t - 1, t + 1, n);
        end
        apb(1'h0, IDX_CTRL0, 32'h0);
        chk("ctrl0 after", c0, rd);
        apb(1'h0, IDX_RESULT, 32'h0);
        chk("result", {24'h0, v}, rd);
        apb(1'h0, IDX_STATUS, 32'h0);
        chk("status done", 32'h1, rd);
        apb(1'h1, IDX_STATUS, 32'h1);
        apb(1'h0, IDX_STATUS, 32'h0);
        chk("status clear", 32'h0, rd);
        chk("done port", 32'h0, {31'h0, done});
    endtask

    // ========================================
    // main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        chk("pins at reset", 32'h1f, {27'h0, analog_pins});
        apb(1'h0, IDX_CTRL0, 32'h0);
        chk("ctrl0 reset", 32'h0, rd);
        apb(1'h0, IDX_PCFG, 32'h0);
        chk("pcfg reset", 32'h0, rd);
        apb(1'h0, 8'h20, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        // go is refused while the converter is still off
        apb(1'h1, IDX_CTRL0, 32'hff);
        apb(1'h0, IDX_CTRL0, 32'h0);
        chk("ctrl0 all ones", 32'hf9, rd);
        chk("power pin", 32'h1, {31'h0, pwr_on});
        chk("no start", 32'h0, {31'h0, sample_hold});
        for (int c = 0; c < NUM_CH; c++) begin
            apb(1'h1, IDX_CTRL0, {26'h0, c[2:0], 3'h0});
            repeat (2) @(posedge pclk);
            chk("channel", c, {29'h0, channel_select});
        end
        for (int p = 0; p < 8; p++) begin
            apb(1'h1, IDX_PCFG, 32'hfffffff8 | p);
            apb(1'h0, IDX_PCFG, 32'h0);
            chk("pcfg read", p, rd);
            chk("analog pins", pins_exp[p], {27'h0, analog_pins});
            chk("ext ref", ref_exp[p], {31'h0, ext_reference});
        end
        apb(1'h1, IDX_CTRL0, 32'h05);
        apb(1'h0, IDX_CTRL0, 32'h0);
        chk("go with power on", 32'h01, rd);
        conv(CS_DIV2, 8'ha5);
        conv(CS_DIV8, 8'h00);
        conv(CS_DIV32, 8'hff);
        rc_run <= 1'h1;
        sleep_mode <= 1'h1;
        conv(CS_RC, 8'h5a);
        // a divided clock stops in sleep, so the conversion stalls
        apb(1'h1, IDX_CTRL0, 32'h05);
        repeat (60) @(posedge pclk);
        apb(1'h0, IDX_STATUS, 32'h0);
        chk("busy in sleep", 32'h2, rd);
        apb(1'h0, IDX_CTRL0, 32'h0);
        chk("stalled go", 32'h05, rd);
        sleep_mode <= 1'h0;
        n = 0;
        wait_done(80);
        apb(1'h1, IDX_STATUS, 32'h1);
        vin <= 8'h3c;
        // power off mid conversion aborts and keeps the old result
        apb(1'h1, IDX_CTRL0, 32'h85);
        repeat (50) @(posedge pclk);
        apb(1'h1, IDX_CTRL0, 32'h80);
        apb(1'h0, IDX_CTRL0, 32'h0);
        chk("abort go", 32'h80, rd);
        chk("abort hold", 32'h0, {31'h0, sample_hold});
        chk("abort power", 32'h0, {31'h0, pwr_on});
        apb(1'h0, IDX_RESULT, 32'h0);
        chk("abort result", 32'h5a, rd);
        // reset in mid conversion
        apb(1'h1, IDX_CTRL0, 32'h41);
        apb(1'h1, IDX_CTRL0, 32'h45);
        repeat (20) @(posedge pclk);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        chk("reset hold", 32'h0, {31'h0, sample_hold});
        chk("reset power", 32'h0, {31'h0, pwr_on});
        apb(1'h0, IDX_CTRL0, 32'h0);
        chk("reset ctrl0", 32'h0, rd);
        apb(1'h0, IDX_PCFG, 32'h0);
        chk("reset pcfg", 32'h0, rd);
        apb(1'h0, IDX_RESULT, 32'h0);
        chk("result kept", 32'h5a, rd);
        summarize();
    end

    // watchdog in case a wait above were ever left unbounded
    initial begin
        repeat (100000) @(posedge pclk);
        fail_count++;
        summarize();
    end
endmodule
